// >>> hw/dioc_pkg.sv
// Constants, register map and mode codes of the discrete I/O rule engine.
// Assumes a single 20 MHz clock; all rule intervals are counted in 1 ms scans.
package dioc_pkg;

    // ----------------------------------------------------------------
    // Channels and rule slots
    // ----------------------------------------------------------------
    localparam int N_DI = 12;
    localparam int N_DO = 6;
    localparam int N_RULES = 16;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_NS = 50;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int MS_PER_S = 1000;
    localparam int SEQ_DELAY_S = 5;
    localparam int FLICK_HALF_MS = 500;
    localparam int PULSE_S = 1;
    localparam int STEP_HALF_MS = 500;
    localparam logic [15:0] SEQ_DELAY_RST = 16'(SEQ_DELAY_S * MS_PER_S);
    localparam logic [15:0] FLICK_HALF_RST = 16'(FLICK_HALF_MS);
    localparam logic [15:0] PULSE_RST = 16'(PULSE_S * MS_PER_S);
    localparam logic [15:0] STEP_HALF_RST = 16'(STEP_HALF_MS);
    localparam logic [2:0] CYCLE_LAST = 3'h6;

    // ----------------------------------------------------------------
    // Register map (byte addresses, word aligned)
    // ----------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_RULE_EN = 8'h04;
    localparam logic [7:0] A_FLICK = 8'h08;
    localparam logic [7:0] A_PULSE = 8'h0c;
    localparam logic [7:0] A_STEP = 8'h10;
    localparam logic [7:0] A_STATUS = 8'h14;
    localparam logic [7:0] A_EVCNT = 8'h18;
    localparam logic [7:0] A_DELAY0 = 8'h20;
    localparam logic [7:0] A_DELAY4 = 8'h30;

    localparam int CTRL_RUN_BIT = 8;
    localparam logic [2:0] CTRL_MODE_RST = 3'h0;
    localparam logic CTRL_RUN_RST = 1'b0;
    localparam logic [15:0] RULE_EN_RST = 16'hffff;
    localparam int ST_FLAG_BIT = 6;
    localparam int ST_PULSE_BIT = 7;
    localparam int ST_CNT_LSB = 8;
    localparam int ST_DI_LSB = 16;

    // ----------------------------------------------------------------
    // Modes and three-input rule operators
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_LATCH = 3'b000,
        MODE_SEQ = 3'b001,
        MODE_WIDE_AND = 3'b010,
        MODE_FLICKER = 3'b011,
        MODE_RISE = 3'b100,
        MODE_FALL = 3'b101,
        MODE_CYCLE = 3'b110,
        MODE_EVENT = 3'b111
    } dioc_mode_t;

    typedef enum logic [1:0] {
        OP_AND = 2'b00,
        OP_OR = 2'b01,
        OP_NAND = 2'b10
    } dioc_op_t;

endpackage

// >>> hw/dioc_tick_if.sv
// Carries the scan strobe from the time base to the rule engine.
// Both ends sit on hclk.
`timescale 1ns/10ps
interface dioc_tick_if;
    logic scan;
    modport src (output scan);
    modport dst (input scan);
endinterface

// >>> hw/dioc_timebase.sv
// Millisecond scan strobe for the rule engine.
// Assumes hclk at the package rate; TICK_CYCLES may be lowered for simulation.
`timescale 1ns/10ps
module dioc_timebase #(
    parameter int TICK_CYCLES = dioc_pkg::TICK_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    dioc_tick_if.src tb
);

    logic [31:0] cnt;
    wire wrap = (cnt == 32'(TICK_CYCLES - 1));

    // Intervals are whole scans, so every timer in the engine counts this pulse.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 32'h0;
            tb.scan <= 1'b0;
        end else begin
            cnt <= wrap ? 32'h0 : cnt + 32'h1;
            tb.scan <= wrap;
        end
    end

endmodule

// >>> hw/dioc_rule_engine.sv
// Rule engine for discrete inputs and outputs, with an AHB-Lite register slave.
// Assumes one 20 MHz clock, field inputs asynchronous to it, word-only bus access.
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
module dioc_rule_engine #(
    parameter int TICK_CYCLES = dioc_pkg::TICK_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [11:0] di,
    output logic [5:0] do_out,
    output logic event_fire
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic rule3(input logic a, input logic b, input logic c,
                                   input dioc_pkg::dioc_op_t op);
        logic r;
        r = 1'b0;
        unique case (op)
            dioc_pkg::OP_AND: r = a & b & c;
            dioc_pkg::OP_OR: r = a | b | c;
            dioc_pkg::OP_NAND: r = ~(a & b & c);
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic reached(input logic [15:0] t, input logic [15:0] lim);
        return (t >= lim);
    endfunction

    // ----------------------------------------------------------------
    // Time base and input synchroniser
    // ----------------------------------------------------------------
    dioc_tick_if tick ();

    dioc_timebase #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timebase (
        .hclk(hclk),
        .hresetn(hresetn),
        .tb(tick)
    );

    logic [11:0] di_meta;
    logic [11:0] di_s;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            di_meta <= 12'h0;
            di_s <= 12'h0;
        end else begin
            di_meta <= di;
            di_s <= di_meta;
        end
    end

    // ----------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // ----------------------------------------------------------------
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [2:0] ctrl_mode;
    logic run;
    logic [15:0] rule_en;
    logic [15:0] flick_half;
    logic [15:0] pulse_len;
    logic [15:0] step_half;
    logic [15:0] seq_delay [5];
    logic [15:0] ev_count;
    logic [31:0] rd_word;

    wire addr_ok = hsel & htrans[1] & hready;
    wire wr_ctrl = wr_pend & (wr_addr == dioc_pkg::A_CTRL);
    wire wr_delay = wr_pend & (wr_addr >= dioc_pkg::A_DELAY0) & (wr_addr <= dioc_pkg::A_DELAY4)
                    & (wr_addr[1:0] == 2'h0);
    wire [7:0] delay_off = wr_addr - dioc_pkg::A_DELAY0;
    wire [2:0] delay_idx = delay_off[4:2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= addr_ok & hwrite;
            wr_addr <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read data is captured in the address phase so hrdata comes from a flop.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (addr_ok & ~hwrite) begin
            hrdata <= rd_word;
        end
    end

    // Every slot is enabled on its own bit; a cleared bit silences that rule.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_mode <= dioc_pkg::CTRL_MODE_RST;
            run <= dioc_pkg::CTRL_RUN_RST;
            rule_en <= dioc_pkg::RULE_EN_RST;
            flick_half <= dioc_pkg::FLICK_HALF_RST;
            pulse_len <= dioc_pkg::PULSE_RST;
            step_half <= dioc_pkg::STEP_HALF_RST;
            for (int k = 0; k < 5; k++) begin
                seq_delay[k] <= dioc_pkg::SEQ_DELAY_RST;
            end
        end else if (wr_pend) begin
            if (wr_ctrl) begin
                ctrl_mode <= hwdata[2:0];
                run <= hwdata[dioc_pkg::CTRL_RUN_BIT];
            end
            if (wr_addr == dioc_pkg::A_RULE_EN) rule_en <= hwdata[15:0];
            if (wr_addr == dioc_pkg::A_FLICK) flick_half <= hwdata[15:0];
            if (wr_addr == dioc_pkg::A_PULSE) pulse_len <= hwdata[15:0];
            if (wr_addr == dioc_pkg::A_STEP) step_half <= hwdata[15:0];
            if (wr_delay) seq_delay[delay_idx] <= hwdata[15:0];
        end
    end

    // ----------------------------------------------------------------
    // Rule state
    // ----------------------------------------------------------------
    dioc_pkg::dioc_mode_t mode;
    assign mode = dioc_pkg::dioc_mode_t'(ctrl_mode);

    logic flag0;
    logic [15:0] timer;
    logic timer_run;
    logic [2:0] step_idx;
    logic pulse_on;
    logic [2:0] seq_cnt;
    logic di_prev;
    logic di0_q;
    logic [7:0] pulse_cnt;
    logic next_flag0;
    logic [15:0] next_timer;
    logic next_timer_run;
    logic [2:0] next_step_idx;
    logic next_pulse_on;
    logic [2:0] next_seq_cnt;
    logic [5:0] next_do;
    logic next_fire;
    logic next_ev;

    always_comb begin
        rd_word = 32'h0;
        case (haddr[7:0])
            dioc_pkg::A_CTRL: rd_word = {23'h0, run, 5'h0, ctrl_mode};
            dioc_pkg::A_RULE_EN: rd_word = {16'h0, rule_en};
            dioc_pkg::A_FLICK: rd_word = {16'h0, flick_half};
            dioc_pkg::A_PULSE: rd_word = {16'h0, pulse_len};
            dioc_pkg::A_STEP: rd_word = {16'h0, step_half};
            dioc_pkg::A_STATUS: begin
                rd_word[5:0] = do_out;
                rd_word[dioc_pkg::ST_FLAG_BIT] = flag0;
                rd_word[dioc_pkg::ST_PULSE_BIT] = pulse_on;
                rd_word[dioc_pkg::ST_CNT_LSB +: 3] = seq_cnt;
                rd_word[dioc_pkg::ST_DI_LSB +: 12] = di_s;
            end
            dioc_pkg::A_EVCNT: rd_word = {8'h0, pulse_cnt, ev_count};
            8'h20, 8'h24, 8'h28, 8'h2c, 8'h30: rd_word = {16'h0, seq_delay[haddr[4:2]]};
            default: rd_word = 32'h0;
        endcase
    end

    wire scan_go = tick.scan & run;
    wire [15:0] t_inc = timer + 16'h1;
    wire rise_clk = di_s[0] & ~di0_q;
    wire edge_seen = (mode == dioc_pkg::MODE_RISE) ? (di_s[0] & ~di_prev) : (~di_s[0] & di_prev);
    wire [3:0] seq_slot = 4'(step_idx) + 4'h1;
    wire pulse_clr = scan_go & (mode == dioc_pkg::MODE_EVENT) & rule_en[0]
                     & (pulse_cnt != 8'h0);

    // Direct chaining: each slot only sees the result of the slot just before it.
    logic [5:0] chain;
    assign chain[0] = rule_en[0] & rule3(di_s[0], di_s[1], di_s[2], dioc_pkg::OP_AND);
    for (genvar g = 1; g < 5; g++) begin : g_chain
        assign chain[g] = rule_en[g] &
                          rule3(chain[g-1], di_s[2*g+1], di_s[2*g+2], dioc_pkg::OP_AND);
    end
    assign chain[5] = rule_en[5] & rule3(chain[4], di_s[11], 1'b1, dioc_pkg::OP_AND);

    // All conditions read the state of the previous scan; results land together at
    // the scan edge, so a flag written now is seen by other rules next scan.
    always_comb begin
        next_flag0 = flag0;
        next_timer = timer;
        next_timer_run = timer_run;
        next_step_idx = step_idx;
        next_pulse_on = pulse_on;
        next_seq_cnt = seq_cnt;
        next_do = do_out;
        next_fire = 1'b0;
        next_ev = 1'b0;
        if (wr_ctrl) begin
            next_flag0 = 1'b0;
            next_timer = 16'h0;
            next_timer_run = 1'b0;
            next_step_idx = 3'h0;
            next_pulse_on = 1'b0;
            next_seq_cnt = 3'h0;
            next_do = 6'h0;
        end else if (scan_go) begin
            unique case (mode)
                dioc_pkg::MODE_LATCH: begin
                    if (rule_en[0] && di_s[0]) next_flag0 = 1'b1;
                    if (rule_en[1]) begin
                        next_do[0] = rule3(flag0, ~di_s[1], 1'b1, dioc_pkg::OP_AND);
                        if (di_s[1]) next_flag0 = 1'b0;
                    end
                end
                dioc_pkg::MODE_SEQ: begin
                    if (timer_run) next_timer = t_inc;
                    if (rule_en[0] && di_s[0]) begin
                        next_do[0] = 1'b1;
                        if (!timer_run && step_idx == 3'h0) begin
                            next_timer_run = 1'b1;
                            next_timer = 16'h0;
                        end
                    end
                    if (timer_run && step_idx < 3'h5 && rule_en[seq_slot]
                        && reached(timer, seq_delay[step_idx])) begin
                        next_do[3'(step_idx + 3'h1)] = 1'b1;
                        next_step_idx = step_idx + 3'h1;
                        next_timer = 16'h0;
                    end
                end
                dioc_pkg::MODE_WIDE_AND: begin
                    next_do[0] = chain[5];
                end
                dioc_pkg::MODE_FLICKER: begin
                    if (rule_en[0]) begin
                        next_timer = t_inc;
                        if (reached(t_inc, flick_half)) begin
                            next_flag0 = rule3(flag0, 1'b1, 1'b1, dioc_pkg::OP_NAND);
                            next_timer = 16'h0;
                        end
                    end
                    if (rule_en[1]) next_do[0] = flag0;
                end
                dioc_pkg::MODE_RISE, dioc_pkg::MODE_FALL: begin
                    if (rule_en[0] && edge_seen) begin
                        next_pulse_on = 1'b1;
                        next_timer = 16'h0;
                        next_timer_run = 1'b1;
                        next_flag0 = 1'b0;
                    end else if (rule_en[1] && timer_run) begin
                        next_timer = t_inc;
                        if (reached(t_inc, pulse_len)) begin
                            next_flag0 = 1'b1;
                            next_timer_run = 1'b0;
                            next_pulse_on = 1'b0;
                        end
                    end
                    if (rule_en[2]) next_do[0] = pulse_on & ~flag0;
                end
                dioc_pkg::MODE_CYCLE: begin
                    if (rule_en[7]) begin
                        next_timer = t_inc;
                        if (reached(t_inc, step_half)) begin
                            next_flag0 = ~flag0;
                            next_timer = 16'h0;
                            if (rule_en[0] && flag0) next_seq_cnt = seq_cnt + 3'h1;
                        end
                    end
                    if (rule_en[14] && seq_cnt >= dioc_pkg::CYCLE_LAST) begin
                        next_seq_cnt = 3'h0;
                    end
                    for (int k = 0; k < 6; k++) begin
                        if (rule_en[8+k]) next_do[k] = (seq_cnt == 3'(k));
                    end
                end
                dioc_pkg::MODE_EVENT: begin
                    if (pulse_clr) begin
                        next_fire = 1'b1;
                        next_ev = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag0 <= 1'b0;
            timer <= 16'h0;
            timer_run <= 1'b0;
            step_idx <= 3'h0;
            pulse_on <= 1'b0;
            seq_cnt <= 3'h0;
            do_out <= 6'h0;
            event_fire <= 1'b0;
        end else begin
            flag0 <= next_flag0;
            timer <= next_timer;
            timer_run <= next_timer_run;
            step_idx <= next_step_idx;
            pulse_on <= next_pulse_on;
            seq_cnt <= next_seq_cnt;
            do_out <= next_do;
            event_fire <= next_fire;
        end
    end

    // A pulse arriving in the clearing cycle is kept: the count restarts at one.
    // A control write restarts the count too, so only an edge in the write cycle itself carries over from another mode.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            di0_q <= 1'b0;
            di_prev <= 1'b0;
            pulse_cnt <= 8'h0;
            ev_count <= 16'h0;
        end else begin
            di0_q <= di_s[0];
            if (scan_go) di_prev <= di_s[0];
            if (pulse_clr || wr_ctrl) begin
                pulse_cnt <= {7'h0, rise_clk};
            end else if (rise_clk && pulse_cnt != 8'hff) begin
                pulse_cnt <= pulse_cnt + 8'h1;
            end
            if (next_ev) ev_count <= ev_count + 16'h1;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    wire chk = scan_go & ~wr_ctrl;

    property p_latch_set;
        chk && mode == dioc_pkg::MODE_LATCH && rule_en[0] && di_s[0]
        && !(rule_en[1] && di_s[1]) |=> flag0;
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch flag not set");

    property p_latch_stop;
        chk && mode == dioc_pkg::MODE_LATCH && rule_en[1] && di_s[1] |=> !do_out[0] && !flag0;
    endproperty
    a_latch_stop: assert property (p_latch_stop) else $error("stop did not win");

    property p_latch_and;
        chk && mode == dioc_pkg::MODE_LATCH && rule_en[1]
        |=> do_out[0] == ($past(flag0) & ~$past(di_s[1]));
    endproperty
    a_latch_and: assert property (p_latch_and) else $error("latch output wrong");

    property p_seq_hold;
        mode == dioc_pkg::MODE_SEQ && !wr_ctrl && do_out[3] |=> do_out[3];
    endproperty
    a_seq_hold: assert property (p_seq_hold) else $error("sequencer output dropped");

    property p_wide_and;
        chk && mode == dioc_pkg::MODE_WIDE_AND && rule_en[5:0] == 6'h3f
        |=> do_out[0] == (&$past(di_s));
    endproperty
    a_wide_and: assert property (p_wide_and) else $error("wide AND mismatch");

    property p_flicker;
        chk && mode == dioc_pkg::MODE_FLICKER && rule_en[1] |=> do_out[0] == $past(flag0);
    endproperty
    a_flicker: assert property (p_flicker) else $error("flicker output wrong");

    property p_edge_arm;
        chk && (mode == dioc_pkg::MODE_RISE || mode == dioc_pkg::MODE_FALL)
        && rule_en[0] && edge_seen |=> pulse_on && !flag0 && timer == 16'h0;
    endproperty
    a_edge_arm: assert property (p_edge_arm) else $error("one-shot not armed");

    property p_edge_expire;
        (mode == dioc_pkg::MODE_RISE || mode == dioc_pkg::MODE_FALL) && flag0 && !wr_ctrl
        && !(tick.scan && edge_seen) && rule_en[2] ##1 tick.scan && run |=> !do_out[0];
    endproperty
    a_edge_expire: assert property (p_edge_expire) else $error("expired flag left output high");

    property p_cycle_bound;
        mode == dioc_pkg::MODE_CYCLE && rule_en[14] |-> seq_cnt <= dioc_pkg::CYCLE_LAST;
    endproperty
    a_cycle_bound: assert property (p_cycle_bound) else $error("step counter overran");

    property p_cycle_step;
        !tick.scan && !wr_ctrl |=> $stable(seq_cnt);
    endproperty
    a_cycle_step: assert property (p_cycle_step) else $error("step counter moved off scan");

    property p_event_once;
        pulse_clr && !wr_ctrl && !rise_clk |=> event_fire && pulse_cnt == 8'h0 ##1 !event_fire;
    endproperty
    a_event_once: assert property (p_event_once) else $error("event not fired once");

    c_latch: cover property (mode == dioc_pkg::MODE_LATCH && $rose(do_out[0]));
    c_seq_done: cover property (mode == dioc_pkg::MODE_SEQ && $rose(do_out[5]));
    c_cycle_wrap: cover property (mode == dioc_pkg::MODE_CYCLE && $fell(seq_cnt == 3'h6));
    c_event: cover property (event_fire);

endmodule

// >>> tb/dioc_field.sv
// Field side: switches that drive the inputs and an actuator that counts event pulses.
// Assumes one clock; switch levels move only at rising edges.
`timescale 1ns/10ps
module dioc_field (
    input wire logic hclk,
    input wire logic [11:0] set_lvl,
    input wire logic event_fire,
    output logic [11:0] di,
    output logic [31:0] fires
);
    initial begin
        di = 12'h000;
        fires = 32'h0;
    end
    always @(posedge hclk) begin
        di <= set_lvl;
        fires <= fires + {31'h0, event_fire};
    end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the rule engine: register bus master and field stimulus.
// Assumes a short scan of TC clocks and zero-wait bus answers.
`timescale 1ns/10ps
module tb_top;
    localparam int TC = 20;
    localparam logic [7:0] RA [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h30, 8'h1c};
    localparam logic [31:0] RV [7] = '{0, 32'hffff, 32'h1f4, 32'h3e8, 32'h1f4, 32'h1388, 0};
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, event_fire;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, fires, r, base;
    logic [11:0] di, set_lvl, v;
    logic [5:0] do_out;
    int mismatches, num_checks, cycles;
    dioc_rule_engine #(.TICK_CYCLES(TC)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .di(di), .do_out(do_out), .event_fire(event_fire));
    dioc_field field (.hclk(hclk), .set_lvl(set_lvl), .event_fire(event_fire), .di(di),
        .fires(fires));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic print_verdict;
        if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // Levels change at a rising edge; the sample lands half a cycle after an edge.
    task automatic step(input logic [11:0] lv, input int n);
        @(posedge hclk);
        set_lvl <= lv;
        repeat (n * TC - 1) @(posedge hclk);
        @(negedge hclk);
    endtask
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 12000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, set_lvl} = '0;
        {mismatches, num_checks, cycles} = '0;
        void'($urandom(32'he5bb));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        check({31'h0, hreadyout}, 32'h1);
        check({26'h0, do_out}, 32'h0);
        check({31'h0, hresp}, 32'h0);
        bus(1'b1, 8'h1c, 32'hffffffff);
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, RA[i], 32'h0);
            check(r, RV[i]);
        end
        bus(1'b1, 8'h00, 32'h100);
        step(12'h001, 3);
        check({31'h0, do_out[0]}, 32'h1);
        step(12'h000, 3);
        check({31'h0, do_out[0]}, 32'h1);
        step(12'h003, 3);
        check({31'h0, do_out[0]}, 32'h0);
        bus(1'b1, 8'h04, 32'hfffe);
        bus(1'b1, 8'h00, 32'h100);
        step(12'h001, 3);
        check({31'h0, do_out[0]}, 32'h0);
        bus(1'b1, 8'h04, 32'hffff);
        bus(1'b1, 8'h00, 32'h102);
        for (int i = 0; i < 8; i++) begin
            v = (i % 3 == 0) ? 12'hfff : 12'($urandom) & ~(12'h1 << ($urandom % 12));
            step(v, 3);
            check({31'h0, do_out[0]}, {31'h0, &v});
        end
        bus(1'b1, 8'h0c, 32'h3);
        for (int m = 4; m < 6; m++) begin
            bus(1'b1, 8'h00, 32'(32'h100 + m));
            step({11'h0, m == 5}, 3);
            step({11'h0, m == 4}, 3);
            check({31'h0, do_out[0]}, 32'h1);
            step({11'h0, m == 4}, 5);
            check({31'h0, do_out[0]}, 32'h0);
        end
        bus(1'b1, 8'h00, 32'h107);
        base = fires;
        repeat (2) begin
            step(12'h001, 3);
            step(12'h000, 3);
        end
        check(fires - base, 32'h2);
        bus(1'b0, 8'h18, 32'h0);
        check(r, 32'h2);
        bus(1'b1, 8'h08, 32'h2);
        bus(1'b1, 8'h00, 32'h103);
        step(12'h000, 3);
        repeat (4) begin
            v[0] = do_out[0];
            step(12'h000, 2);
            check({31'h0, do_out[0]}, {31'h0, ~v[0]});
        end
        for (int k = 0; k < 5; k++) bus(1'b1, 8'(8'h20 + 4 * k), 32'h2);
        bus(1'b1, 8'h00, 32'h101);
        step(12'h001, 2);
        check({26'h0, do_out}, 32'h1);
        step(12'h000, 20);
        check({26'h0, do_out}, 32'h3f);
        bus(1'b1, 8'h10, 32'h1);
        bus(1'b1, 8'h00, 32'h106);
        v = 12'h0;
        repeat (16) begin
            step(12'h000, 1);
            v[5:0] = v[5:0] | do_out;
            check({31'h0, $countones(do_out) <= 1}, 32'h1);
        end
        check({20'h0, v}, 32'h3f);
        print_verdict();
    end
endmodule
